// *** vmd_defs.vh ***
// constants for the viterbi metric datapath
`ifndef VMD_DEFS_VH
`define VMD_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets (avalon word address = offset / 4)
// ----------------------------------------------------------------
`define VMD_OFS_VREG_BASE 8'h00
`define VMD_OFS_VREG_LAST 8'h20
`define VMD_OFS_STATUS_WORD 8'h24
`define VMD_OFS_COMMAND 8'h28
`define VMD_OFS_IRQ_STATUS 8'h2c
`define VMD_OFS_IRQ_MASK 8'h30
`define VMD_OFS_BUSY 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VMD_SW_SAT_BIT 0
`define VMD_SW_OVF_BIT 1
`define VMD_IRQ_DONE_BIT 0
`define VMD_IRQ_OVF_BIT 1
`define VMD_NUM_VREGS 9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VMD_RST_WORD 32'h0000_0000
`define VMD_RST_FLAGS 2'h0

// ----------------------------------------------------------------
// instruction words
// ----------------------------------------------------------------
`define VMD_OP_BM3_LOAD 16'he3fd
`define VMD_OP_HADDSUB_HI 12'he57
`define VMD_OP_HADDSUB_ST 16'he509
`define VMD_OP_HSUBADD_HI 12'he5f
`define VMD_OP_HSUBADD_ST 16'he205

// ----------------------------------------------------------------
// timing counts in clock cycles
// ----------------------------------------------------------------
`define VMD_BM3_LATENCY 2
`define VMD_LOAD_LATENCY 1

`endif

// *** vmd_metric_sum.v ***
// three-input signed 16-bit sum with optional saturation
`timescale 1ns/1ps
`default_nettype none
module vmd_metric_sum (
  input wire [15:0] in_a,
  input wire [15:0] in_b,
  input wire [15:0] in_c,
  input wire sub_b,
  input wire sub_c,
  input wire sat_en,
  output reg [15:0] result,
  output reg overflow
);
  wire [17:0] ext_a;
  wire [17:0] ext_b;
  wire [17:0] ext_c;
  reg [17:0] total;

  assign ext_a = {{2{in_a[15]}}, in_a};
  assign ext_b = {{2{in_b[15]}}, in_b};
  assign ext_c = {{2{in_c[15]}}, in_c};

  always @* begin
    total = ext_a + (sub_b ? (~ext_b + 18'h0_0001) : ext_b);
    total = total + (sub_c ? (~ext_c + 18'h0_0001) : ext_c);
    overflow = ~((total[17:15] == 3'h0) || (total[17:15] == 3'h7));
    if (overflow && sat_en) begin
      result = total[17] ? 16'h8000 : 16'h7fff;
    end else begin
      result = total[15:0];
    end
  end
endmodule
`default_nettype wire

// *** vmd_datapath.v ***
// viterbi branch and path metric datapath with avalon-mm registers
// Behaviour
// - rate-third metrics: four signed sums of i0,i1,i2
// - metrics land in vreg0 low/high, vreg1 low/high
// - parallel load of vreg2; sums use old value
// - saturate metrics when saturate_enable set
// - set overflow flag on any metric overflow
// - metrics after two cycles, load after one
// - add-sub: s0+b, s1-b, s0-b, s1+b, b high
// - path metrics to vreg3 low/high, vreg4 low/high
// - add-sub with store writes store source out
// - sub-add: s0-b, s1+b, s0+b, s1-b
// - sub-add with store, b high, stores source
// - butterfly instructions leave the status word alone, but set the done bit in irq status
// - butterfly finishes in one cycle
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "vmd_defs.vh"
module vmd_datapath (
  input wire CLOCK,
  input wire RST_B,
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  output reg [7:0] MEM_ADDRESS,
  output reg MEM_READ,
  output reg MEM_WRITE,
  output reg [31:0] MEM_WRITEDATA,
  input wire [31:0] MEM_READDATA,
  output reg IRQ
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [31:0] vreg [0:`VMD_NUM_VREGS-1];
  reg sat_reg;
  reg ovf_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg stage1_reg;
  reg stage2_reg;
  reg load_reg;
  reg [15:0] in0_reg;
  reg [15:0] in1_reg;
  reg [15:0] in2_reg;
  reg [1:0] irq_status_next;
  reg ovf_next;
  integer k;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [7:0] byte_addr;
  wire busy;
  wire accept;
  wire wr_acc;
  wire is_vreg;
  wire [3:0] vreg_idx;
  wire [15:0] lsw;
  wire [15:0] msw;
  wire [3:0] src_sel;
  wire [3:0] st_sel;
  wire cmd_wr;
  wire do_bm3;
  wire do_hadd;
  wire do_hsub;
  wire do_store;
  wire do_fly;
  wire [31:0] wmask;

  assign byte_addr = {AVS_ADDRESS, 2'b00};
  assign busy = stage1_reg | stage2_reg | load_reg;
  assign accept = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign wr_acc = accept & AVS_WRITE;
  assign is_vreg = byte_addr <= `VMD_OFS_VREG_LAST;
  assign vreg_idx = AVS_ADDRESS[3:0];
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  assign lsw = AVS_WRITEDATA[15:0];
  assign msw = AVS_WRITEDATA[31:16];
  assign cmd_wr = wr_acc && (byte_addr == `VMD_OFS_COMMAND);
  assign do_bm3 = cmd_wr && (lsw == `VMD_OP_BM3_LOAD);
  assign do_hadd = cmd_wr && ((lsw[15:4] == `VMD_OP_HADDSUB_HI) ||
                              (lsw == `VMD_OP_HADDSUB_ST));
  assign do_hsub = cmd_wr && ((lsw[15:4] == `VMD_OP_HSUBADD_HI) ||
                              (lsw == `VMD_OP_HSUBADD_ST));
  assign do_store = cmd_wr && ((lsw == `VMD_OP_HADDSUB_ST) ||
                               (lsw == `VMD_OP_HSUBADD_ST));
  assign do_fly = do_hadd | do_hsub;
  // source field sits in the opcode or, for store forms, the second word
  assign src_sel = do_store ? msw[11:8] : lsw[3:0];
  assign st_sel = msw[15:12];

  // ----------------------------------------------------------------
  // butterfly path metrics
  // ----------------------------------------------------------------
  wire [15:0] bmet;
  wire [15:0] st0;
  wire [15:0] st1;
  wire [31:0] st_data;
  wire [15:0] pm0;
  wire [15:0] pm1;
  wire [15:0] pm2;
  wire [15:0] pm3;

  // out-of-range selections read as zero
  assign bmet = (src_sel < `VMD_NUM_VREGS) ? vreg[src_sel][31:16] :
                16'h0000;
  assign st_data = (st_sel < `VMD_NUM_VREGS) ? vreg[st_sel] :
                   `VMD_RST_WORD;
  assign st0 = vreg[2][15:0];
  assign st1 = vreg[2][31:16];
  // plain 16-bit adds wrap on purpose
  assign pm0 = do_hsub ? st0 - bmet : st0 + bmet;
  assign pm1 = do_hsub ? st1 + bmet : st1 - bmet;
  assign pm2 = do_hsub ? st0 + bmet : st0 - bmet;
  assign pm3 = do_hsub ? st1 - bmet : st1 + bmet;

  // ----------------------------------------------------------------
  // branch metric adders
  // ----------------------------------------------------------------
  wire [15:0] bm0;
  wire [15:0] bm1;
  wire [15:0] bm2;
  wire [15:0] bm3;
  wire [3:0] bm_ovf;

  vmd_metric_sum u_bm0 (
    .in_a(in0_reg), .in_b(in1_reg), .in_c(in2_reg),
    .sub_b(1'b0), .sub_c(1'b0), .sat_en(sat_reg),
    .result(bm0), .overflow(bm_ovf[0])
  );
  vmd_metric_sum u_bm1 (
    .in_a(in0_reg), .in_b(in1_reg), .in_c(in2_reg),
    .sub_b(1'b0), .sub_c(1'b1), .sat_en(sat_reg),
    .result(bm1), .overflow(bm_ovf[1])
  );
  vmd_metric_sum u_bm2 (
    .in_a(in0_reg), .in_b(in1_reg), .in_c(in2_reg),
    .sub_b(1'b1), .sub_c(1'b0), .sat_en(sat_reg),
    .result(bm2), .overflow(bm_ovf[2])
  );
  vmd_metric_sum u_bm3 (
    .in_a(in0_reg), .in_b(in1_reg), .in_c(in2_reg),
    .sub_b(1'b1), .sub_c(1'b1), .sat_en(sat_reg),
    .result(bm3), .overflow(bm_ovf[3])
  );

  wire bm_done;
  wire bm_over;
  assign bm_done = stage2_reg;
  assign bm_over = stage2_reg & (|bm_ovf);

  // ----------------------------------------------------------------
  // pipeline and memory port
  // ----------------------------------------------------------------
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      load_reg <= 1'b0;
      in0_reg <= 16'h0000;
      in1_reg <= 16'h0000;
      in2_reg <= 16'h0000;
      MEM_ADDRESS <= 8'h00;
      MEM_READ <= 1'b0;
      MEM_WRITE <= 1'b0;
      MEM_WRITEDATA <= `VMD_RST_WORD;
    end else begin
      // two stages give the metrics their two-cycle latency
      stage1_reg <= do_bm3;
      stage2_reg <= stage1_reg;
      load_reg <= do_bm3;
      MEM_READ <= do_bm3;
      MEM_WRITE <= do_store;
      if (do_bm3) begin
        // operands captured before the load can touch vreg2
        in0_reg <= vreg[0][15:0];
        in1_reg <= vreg[1][15:0];
        in2_reg <= vreg[2][15:0];
        MEM_ADDRESS <= msw[7:0];
      end else if (do_store) begin
        MEM_ADDRESS <= msw[7:0];
        MEM_WRITEDATA <= st_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // vector registers
  // ----------------------------------------------------------------
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      for (k = 0; k < `VMD_NUM_VREGS; k = k + 1) begin
        vreg[k] <= `VMD_RST_WORD;
      end
    end else begin
      if (wr_acc && is_vreg) begin
        vreg[vreg_idx] <= (vreg[vreg_idx] & ~wmask) |
                          (AVS_WRITEDATA & wmask);
      end
      if (do_fly) begin
        vreg[3] <= {pm1, pm0};
        vreg[4] <= {pm3, pm2};
      end
      if (load_reg) begin
        vreg[2] <= MEM_READDATA;
      end
      if (stage2_reg) begin
        vreg[0] <= {bm1, bm0};
        vreg[1] <= {bm3, bm2};
      end
    end
  end

  // ----------------------------------------------------------------
  // status word and interrupts
  // ----------------------------------------------------------------
  always @* begin
    ovf_next = ovf_reg;
    irq_status_next = irq_status_reg;
    if (wr_acc && (byte_addr == `VMD_OFS_STATUS_WORD) &&
        AVS_BYTEENABLE[0] && AVS_WRITEDATA[`VMD_SW_OVF_BIT]) begin
      ovf_next = 1'b0;
    end
    if (wr_acc && (byte_addr == `VMD_OFS_IRQ_STATUS) &&
        AVS_BYTEENABLE[0]) begin
      irq_status_next = irq_status_reg & ~AVS_WRITEDATA[1:0];
    end
    // hardware set wins over a clear in the same cycle
    if (bm_over) begin
      ovf_next = 1'b1;
      irq_status_next[`VMD_IRQ_OVF_BIT] = 1'b1;
    end
    if (bm_done || do_fly) begin
      irq_status_next[`VMD_IRQ_DONE_BIT] = 1'b1;
    end
  end

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sat_reg <= 1'b0;
      ovf_reg <= 1'b0;
      irq_status_reg <= `VMD_RST_FLAGS;
      irq_mask_reg <= `VMD_RST_FLAGS;
      IRQ <= 1'b0;
    end else begin
      // butterfly forms never reach ovf_next
      ovf_reg <= ovf_next;
      irq_status_reg <= irq_status_next;
      if (wr_acc && (byte_addr == `VMD_OFS_STATUS_WORD) &&
          AVS_BYTEENABLE[0]) begin
        sat_reg <= AVS_WRITEDATA[`VMD_SW_SAT_BIT];
      end
      if (wr_acc && (byte_addr == `VMD_OFS_IRQ_MASK) &&
          AVS_BYTEENABLE[0]) begin
        irq_mask_reg <= AVS_WRITEDATA[1:0];
      end
      IRQ <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // avalon answer
  // ----------------------------------------------------------------
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= `VMD_RST_WORD;
    end else begin
      // accesses held off while the branch metric pipe is in flight
      if (!AVS_WAITREQUEST) begin
        AVS_WAITREQUEST <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && !busy) begin
        AVS_WAITREQUEST <= 1'b0;
      end
      if (AVS_READ && AVS_WAITREQUEST && !busy) begin
        if (is_vreg) begin
          AVS_READDATA <= vreg[vreg_idx];
        end else begin
          case (byte_addr)
            `VMD_OFS_STATUS_WORD:
              AVS_READDATA <= {30'h0000_0000, ovf_reg, sat_reg};
            `VMD_OFS_IRQ_STATUS:
              AVS_READDATA <= {30'h0000_0000, irq_status_reg};
            `VMD_OFS_IRQ_MASK:
              AVS_READDATA <= {30'h0000_0000, irq_mask_reg};
            default:
              AVS_READDATA <= `VMD_RST_WORD;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** vmd_datapath_monitor.sv ***
// port checker for the viterbi metric datapath
`timescale 1ns/1ps
`default_nettype none
module vmd_datapath_monitor (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [7:0] MEM_ADDRESS,
  input wire logic MEM_READ,
  input wire logic MEM_WRITE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  wire logic acc = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 6'h0a;
  wire logic [15:0] op = AVS_WRITEDATA[15:0];
  wire logic [7:0] sec_addr = AVS_WRITEDATA[23:16];
  wire logic bm3 = acc && op == 16'he3fd;
  wire logic st = acc && (op == 16'he509 || op == 16'he205);
  a_wait_one_low: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_wait_has_req: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("waitrequest low without a request");
  a_load_on_issue: assert property (
    bm3 |=> MEM_READ && MEM_ADDRESS == $past(sec_addr))
    else $error("load request missing after metric issue");
  a_load_cause: assert property (MEM_READ |-> $past(bm3))
    else $error("load request without metric issue");
  a_store_on_issue: assert property (
    st |=> MEM_WRITE && MEM_ADDRESS == $past(sec_addr))
    else $error("store missing after butterfly issue");
  a_store_cause: assert property (MEM_WRITE |-> $past(st))
    else $error("store without butterfly issue");
  a_load_pulse: assert property (MEM_READ |=> !MEM_READ)
    else $error("load request longer than one cycle");
  a_metric_stall: assert property (bm3 |=> AVS_WAITREQUEST [*2])
    else $error("bus answered while metric pipe busy");
  c_metric: cover property (bm3);
  c_store: cover property (st);
  c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind vmd_datapath vmd_datapath_monitor mon_u (.CLOCK, .RST_B, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_WAITREQUEST, .MEM_ADDRESS,
  .MEM_READ, .MEM_WRITE);
`default_nettype wire

// *** vmd_mem_model.sv ***
// data memory model on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module vmd_mem_model (
  input wire logic clock,
  input wire logic [7:0] mem_address,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [31:0] mem_writedata,
  output logic [31:0] mem_readdata
);
  logic [31:0] mem [0:255];
  logic [31:0] last = 32'h0;
  // idle bus shows the inverse of the last word
  assign mem_readdata = mem_read ? mem[mem_address] : ~last;
  always @(posedge clock) begin
    if (mem_read) last <= mem[mem_address];
    if (mem_write) mem[mem_address] <= mem_writedata;
  end
endmodule
`default_nettype wire

// *** test_vmd_datapath.sv ***
// self-checking bench for the viterbi metric datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_vmd_datapath;
  logic CLOCK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic MEM_READ, MEM_WRITE, IRQ, o, sub, store;
  logic [5:0] AVS_ADDRESS;
  logic [3:0] AVS_BYTEENABLE;
  logic [7:0] MEM_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, MEM_WRITEDATA, MEM_READDATA;
  logic [31:0] seed, q, v0, v1, v2, md, sw, st;
  logic [16:0] e0, e1, e2, e3;
  logic [15:0] b, msw, opw;
  logic [63:0] pv;
  int bad_count, n_tests;
  vmd_datapath dut_u (.CLOCK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .MEM_ADDRESS, .MEM_READ, .MEM_WRITE, .MEM_WRITEDATA, .MEM_READDATA, .IRQ);
  vmd_mem_model mem_u (.clock(CLOCK), .mem_address(MEM_ADDRESS),
    .mem_read(MEM_READ), .mem_write(MEM_WRITE),
    .mem_writedata(MEM_WRITEDATA), .mem_readdata(MEM_READDATA));
  initial begin
    CLOCK = 1'b0;
    forever #4 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // signed three-input sum, flag in bit 16
  function automatic logic [16:0] bm(input logic [15:0] a, c, d,
    input logic sc, sd, sat);
    logic [17:0] x, y, z, s;
    logic ov;
    x = {{2{a[15]}}, a};
    y = {{2{c[15]}}, c};
    z = {{2{d[15]}}, d};
    s = x + (sc ? -y : y) + (sd ? -z : z);
    ov = s[17:15] != {3{s[15]}};
    return {ov, (ov && sat) ? (s[17] ? 16'h8000 : 16'h7fff) : s[15:0]};
  endfunction
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    if (AVS_WAITREQUEST !== 1'b0) begin
      `CHK("bus wait", 1'b0, AVS_WAITREQUEST)
      test_done();
    end
    // answer taken at the accepting edge, then released
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, '0);
  endtask
  task test_done;
    $display("%0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    seed = 32'ha19c_ddfa;
    RST_B = 1'b0;
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    AVS_BYTEENABLE = 4'hf;
    repeat (20) @(posedge CLOCK);
    RST_B <= 1'b1;
    @(posedge CLOCK);
    for (int i = 0; i < 14; i++) begin
      rd(i[5:0]);
      `CHK("reset word", 32'h0, q)
    end
    wr(6'h20, rnd());
    rd(6'h20);
    `CHK("unmapped word", 32'h0, q)
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      v0 = rnd(); v1 = rnd(); v2 = rnd(); md = rnd(); sw = rnd();
      if (k < 2) begin
        v0[15:0] = 16'h7fff;
        v1[15:0] = k ? 16'h8001 : 16'h7fff;
        v2[15:0] = 16'h7fff;
      end
      wr(6'h00, v0); wr(6'h01, v1); wr(6'h02, v2);
      wr(6'h09, {30'h0, 1'b1, sw[0]});
      wr(6'h0b, 32'h3);
      wr(6'h0c, {30'h0, sw[2:1]});
      mem_u.mem[md[7:0]] = md;
      wr(6'h0a, {8'h00, md[7:0], 16'he3fd});
      rd(6'h02);
      `CHK("loaded word", md, q)
      e0 = bm(v0[15:0], v1[15:0], v2[15:0], 1'b0, 1'b0, sw[0]);
      e1 = bm(v0[15:0], v1[15:0], v2[15:0], 1'b0, 1'b1, sw[0]);
      e2 = bm(v0[15:0], v1[15:0], v2[15:0], 1'b1, 1'b0, sw[0]);
      e3 = bm(v0[15:0], v1[15:0], v2[15:0], 1'b1, 1'b1, sw[0]);
      o = e0[16] | e1[16] | e2[16] | e3[16];
      rd(6'h00);
      `CHK("metrics low", {e1[15:0], e0[15:0]}, q)
      rd(6'h01);
      `CHK("metrics high", {e3[15:0], e2[15:0]}, q)
      rd(6'h09);
      `CHK("status word", {o, sw[0]}, q[1:0])
      rd(6'h0b);
      `CHK("event bits", {o, 1'b1}, q[1:0])
      `CHK("irq line", |({o, 1'b1} & sw[2:1]), IRQ)
      wr(6'h0b, 32'h3);
      rd(6'h0b);
      `CHK("irq cleared", 1'b0, IRQ)
    end
    $display("test branch metric done");
    for (int k = 0; k < 16; k++) begin
      v0 = rnd(); v1 = rnd(); v2 = rnd(); md = rnd(); sw = rnd();
      sub = k[0];
      store = k[1];
      wr(6'h00, v0); wr(6'h01, v1); wr(6'h02, v2);
      wr(6'h05 + {4'h0, sw[1:0]}, md);
      rd(6'h09);
      st = q;
      b = sw[2] ? v1[31:16] : v0[31:16];
      opw = store ? (sub ? 16'he205 : 16'he509)
        : {sub ? 12'he5f : 12'he57, 3'b000, sw[2]};
      msw = {4'h5 + {2'b00, sw[1:0]}, 3'b000, sw[2], sw[15:8]};
      mem_u.mem[sw[15:8]] = ~md;
      wr(6'h0a, {msw, opw});
      pv = sub ? {v2[31:16] - b, v2[15:0] + b, v2[31:16] + b, v2[15:0] - b}
        : {v2[31:16] + b, v2[15:0] - b, v2[31:16] - b, v2[15:0] + b};
      rd(6'h03);
      `CHK("path low", pv[31:0], q)
      rd(6'h04);
      `CHK("path high", pv[63:32], q)
      rd(6'h09);
      `CHK("status kept", st, q)
      `CHK("memory word", store ? md : ~md, mem_u.mem[sw[15:8]])
    end
    $display("test butterfly done");
    test_done();
  end
endmodule
`default_nettype wire
